// ---- rtl/bst_selftest_ctrl.v ----
// Summary of operation
// - Bad checksum: test never starts, no lamp write, lamps stay lit.
// - Lamps 1, 2, 3 carry the running module number in binary.
// - Modules run in order 1 to 6; module 6 only reports.
// - On a hang the lamps keep the stalled module's number.
// - After module 6 the lamps show only fault flags; clean unit all off.
// - Lamp 4 lights on any bus error or trap during testing.
// - Lamp 5 is reserved; no lamp write ever lights it, only power-on does.
// - Lamps 6, 7, 8 flag palette, frame controller, interface faults.
// - Each failure gives a console message code and a lamp state.
// - Final module reports functional or not functional.
// - Bus faults during testing are caught and recorded, never fatal.
// - Overlay memory is exercised with byte, word and long word widths.
// - Slow moves use rules 00,33,66,CC,FF; fast moves 00 and FF only.
`timescale 1ns/10ps
`default_nettype none
`include "bst_map.vh"
module bst_selftest_ctrl (
	input  wire        clock,
	input  wire        rst,
	input  wire [7:0]  s_awaddr,
	input  wire        s_awvalid,
	output wire        s_awready,
	input  wire [31:0] s_wdata,
	input  wire [3:0]  s_wstrb,
	input  wire        s_wvalid,
	output wire        s_wready,
	output wire [1:0]  s_bresp,
	output wire        s_bvalid,
	input  wire        s_bready,
	input  wire [7:0]  s_araddr,
	input  wire        s_arvalid,
	output wire        s_arready,
	output wire [31:0] s_rdata,
	output wire [1:0]  s_rresp,
	output wire        s_rvalid,
	input  wire        s_rready,
	input  wire        dev_bus_fault,
	output reg         lamp_we,
	output reg  [7:0]  lamp_wdata,
	output reg         irq
);
	localparam ST_IDLE  = 3'h0;
	localparam ST_RUN   = 3'h1;
	localparam ST_FINAL = 3'h2;
	localparam ST_DONE  = 3'h3;
	localparam ST_ABORT = 3'h4;

	reg  [2:0]  state_r;
	reg  [2:0]  mod_r;
	reg  [2:0]  item_r;
	reg  [3:0]  faults_r;
	reg  [3:0]  msg_r;
	reg         csum_ok_r;
	reg         func_r;
	reg         nfunc_r;
	reg  [3:0]  mask_r;
	reg  [3:0]  ev_r;
	reg  [7:0]  lamp_r;
	reg  [31:0] rd_data;
	reg  [3:0]  ev_set;
	reg  [3:0]  faults_nxt;
	wire        wr_stb;
	wire [7:0]  wr_addr;
	wire [31:0] wr_data;
	wire        start;
	wire        report;
	wire        fault_in;
	wire [3:0]  rpt;
	wire        last_item;
	wire        csum_now;

	bst_axil_slave u_bus (
		.clock     (clock),
		.rst       (rst),
		.s_awaddr  (s_awaddr),
		.s_awvalid (s_awvalid),
		.s_awready (s_awready),
		.s_wdata   (s_wdata),
		.s_wstrb   (s_wstrb),
		.s_wvalid  (s_wvalid),
		.s_wready  (s_wready),
		.s_bresp   (s_bresp),
		.s_bvalid  (s_bvalid),
		.s_bready  (s_bready),
		.s_araddr  (s_araddr),
		.s_arvalid (s_arvalid),
		.s_arready (s_arready),
		.s_rdata   (s_rdata),
		.s_rresp   (s_rresp),
		.s_rvalid  (s_rvalid),
		.s_rready  (s_rready),
		.rd_data   (rd_data),
		.wr_stb    (wr_stb),
		.wr_addr   (wr_addr),
		.wr_data   (wr_data)
	);

	// lamp word: interface, frame ctrl, palette, reserved, bus error, module
	function [7:0] lamp_word;
		input [2:0] m;
		input [3:0] f;
		begin
			lamp_word = {f[`BST_RPT_HIF], f[`BST_RPT_FMC], f[`BST_RPT_PAL],
				1'b0,
				f[`BST_RPT_BUS],
				m};
		end
	endfunction

	// modules 1, 3 and 4 each count as a single item
	function [2:0] item_count;
		input [2:0] m;
		begin
			if (m == `BST_MOD_FMC)
				item_count = `BST_ITEMS_FMC;
			else if (m == `BST_MOD_MOVER)
				item_count = `BST_ITEMS_MOVER;
			else
				item_count = `BST_ITEMS_ONE;
		end
	endfunction

	// plan word: bit 8 marks a fast move, low byte is access width or rule code
	function [8:0] plan_word;
		input [2:0] m;
		input [2:0] i;
		begin
			plan_word = 9'h000;
			if (m == `BST_MOD_FMC) begin
				case (i)
					3'h0: plan_word = 9'h001;
					3'h1: plan_word = 9'h002;
					default: plan_word = 9'h004;
				endcase
			end else if (m == `BST_MOD_MOVER) begin
				case (i)
					3'h0: plan_word = 9'h000;
					3'h1: plan_word = 9'h033;
					3'h2: plan_word = 9'h066;
					3'h3: plan_word = 9'h0CC;
					3'h4: plan_word = 9'h0FF;
					3'h5: plan_word = 9'h100;
					default: plan_word = 9'h1FF;
				endcase
			end
		end
	endfunction

	// bus error outranks unit faults; one code per report
	function [3:0] msg_of;
		input [2:0] m;
		input [3:0] f;
		begin
			if (f[`BST_RPT_BUS])
				msg_of = `BST_MSG_BUS;
			else if (f[`BST_RPT_HIF])
				msg_of = `BST_MSG_HIF;
			else if (f[`BST_RPT_FMC])
				msg_of = (m == `BST_MOD_MOVER) ? `BST_MSG_FMC_MOVE : `BST_MSG_FMC_RW;
			else if (f[`BST_RPT_PAL] && m == `BST_MOD_PAL_MEM)
				msg_of = `BST_MSG_PAL_MEM;
			else if (f[`BST_RPT_PAL] && m == `BST_MOD_PAL_ALU)
				msg_of = `BST_MSG_PAL_ALU;
			else if (f[`BST_RPT_PAL])
				msg_of = `BST_MSG_PAL_RW;
			else
				msg_of = `BST_MSG_NONE;
		end
	endfunction

	assign start     = wr_stb && (wr_addr == `BST_OFS_CTRL) && wr_data[`BST_CTRL_START];
	assign report    = wr_stb && (wr_addr == `BST_OFS_REPORT) && (state_r == ST_RUN);
	// faults outside a run belong to no module and are dropped
	assign fault_in  = dev_bus_fault && (state_r == ST_RUN);
	// the checksum flag written with START decides, so one word arms and starts
	assign csum_now  = wr_data[`BST_CTRL_CSUM_OK];
	assign rpt       = report ? wr_data[3:0] : 4'h0;
	assign last_item = (item_r + 3'h1) >= item_count(mod_r);

	always @* begin
		faults_nxt = faults_r | rpt | {3'h0, fault_in};
		ev_set = 4'h0;
		ev_set[`BST_EV_MOD_DONE]  = report && last_item;
		ev_set[`BST_EV_FINISH]    = (state_r == ST_FINAL);
		ev_set[`BST_EV_CSUM_FAIL] = start && !csum_now && (state_r != ST_RUN);
		ev_set[`BST_EV_BUS_FAULT] = fault_in;
	end

	always @(posedge clock) begin
		if (rst) begin
			// no lamp write here: lamps keep what they show across this reset
			state_r    <= ST_IDLE;
			mod_r      <= 3'h0;
			item_r     <= 3'h0;
			faults_r   <= 4'h0;
			msg_r      <= `BST_MSG_NONE;
			csum_ok_r  <= `BST_CTRL_RST;
			func_r     <= 1'b0;
			nfunc_r    <= 1'b0;
			mask_r     <= `BST_MASK_RST;
			ev_r       <= 4'h0;
			lamp_r     <= `BST_LAMP_RST;
			lamp_we    <= 1'b0;
			lamp_wdata <= `BST_LAMP_RST;
			irq        <= 1'b0;
		end else begin
			lamp_we <= 1'b0;
			if (wr_stb && wr_addr == `BST_OFS_CTRL)
				csum_ok_r <= wr_data[`BST_CTRL_CSUM_OK];
			if (wr_stb && wr_addr == `BST_OFS_IRQ_MASK)
				mask_r <= wr_data[3:0];
			// a set in the same cycle as its clear wins
			if (wr_stb && wr_addr == `BST_OFS_IRQ_STAT)
				ev_r <= (ev_r & ~wr_data[3:0]) | ev_set;
			else
				ev_r <= ev_r | ev_set;
			// one cycle behind the status bits so irq leaves a flop
			irq <= |(ev_r & mask_r);
			case (state_r)
				ST_RUN: begin
					faults_r <= faults_nxt;
					if (msg_of(mod_r, rpt | {3'h0, fault_in}) != `BST_MSG_NONE)
						msg_r <= msg_of(mod_r, rpt | {3'h0, fault_in});
					if (report && !last_item) begin
						item_r <= item_r + 3'h1;
					end else if (report) begin
						item_r <= 3'h0;
						mod_r  <= mod_r + 3'h1;
						if (mod_r == `BST_MOD_MOVER)
							state_r <= ST_FINAL;
					end
					// module number, plus the bus error lamp once it is seen
					if ((report && last_item) ||
						(faults_nxt[`BST_RPT_BUS] && !faults_r[`BST_RPT_BUS])) begin
						lamp_we    <= 1'b1;
						lamp_wdata <= lamp_word(report && last_item ?
							mod_r + 3'h1 : mod_r, {3'h0, faults_nxt[`BST_RPT_BUS]});
						lamp_r     <= lamp_word(report && last_item ?
							mod_r + 3'h1 : mod_r, {3'h0, faults_nxt[`BST_RPT_BUS]});
					end
				end
				ST_FINAL: begin
					lamp_we    <= 1'b1;
					lamp_wdata <= lamp_word(3'h0, faults_r);
					lamp_r     <= lamp_word(3'h0, faults_r);
					func_r     <= (faults_r == 4'h0);
					nfunc_r    <= (faults_r != 4'h0);
					msg_r      <= (faults_r == 4'h0) ? `BST_MSG_FUNC : `BST_MSG_NOT_FUNC;
					state_r    <= ST_DONE;
				end
				ST_IDLE, ST_DONE, ST_ABORT: begin
					// abort writes nothing, so the power-on lamps stay lit
					if (start && !csum_now) begin
						state_r <= ST_ABORT;
					end else if (start) begin
						state_r    <= ST_RUN;
						mod_r      <= `BST_MOD_INIT;
						item_r     <= 3'h0;
						faults_r   <= 4'h0;
						msg_r      <= `BST_MSG_NONE;
						func_r     <= 1'b0;
						nfunc_r    <= 1'b0;
						lamp_we    <= 1'b1;
						lamp_wdata <= lamp_word(`BST_MOD_INIT, 4'h0);
						lamp_r     <= lamp_word(`BST_MOD_INIT, 4'h0);
					end
				end
				// codes 5 to 7 are never entered; fall back to idle if upset
				default:
					state_r <= ST_IDLE;
			endcase
			// no timeout: a stalled module leaves its number on the lamps
		end
	end

	always @* begin
		if (s_araddr == `BST_OFS_CTRL)
			rd_data = {30'h0, csum_ok_r, 1'b0};
		else if (s_araddr == `BST_OFS_STATUS)
			rd_data = {16'h0, msg_r, faults_r, nfunc_r, func_r, state_r, mod_r};
		else if (s_araddr == `BST_OFS_LAMP)
			rd_data = {24'h0, lamp_r};
		else if (s_araddr == `BST_OFS_IRQ_STAT)
			rd_data = {28'h0, ev_r};
		else if (s_araddr == `BST_OFS_IRQ_MASK)
			rd_data = {28'h0, mask_r};
		else if (s_araddr == `BST_OFS_PLAN)
			rd_data = {20'h0, item_r, plan_word(mod_r, item_r)};
		else
			rd_data = 32'h00000000;
	end
endmodule
`default_nettype wire

// ---- rtl/bst_map.vh ----
`ifndef BST_MAP_VH
`define BST_MAP_VH
// register byte offsets on the command bus
`define BST_OFS_CTRL      8'h00
`define BST_OFS_REPORT    8'h04
`define BST_OFS_STATUS    8'h08
`define BST_OFS_LAMP      8'h0C
`define BST_OFS_IRQ_STAT  8'h10
`define BST_OFS_IRQ_MASK  8'h14
`define BST_OFS_PLAN      8'h18
// control register fields
`define BST_CTRL_START    0
`define BST_CTRL_CSUM_OK  1
// report fields, also the layout of the accumulated fault word
`define BST_RPT_BUS       0
`define BST_RPT_PAL       1
`define BST_RPT_FMC       2
`define BST_RPT_HIF       3
// event bits of the interrupt status and mask registers
`define BST_EV_MOD_DONE   0
`define BST_EV_FINISH     1
`define BST_EV_CSUM_FAIL  2
`define BST_EV_BUS_FAULT  3
// reset values
`define BST_CTRL_RST      1'b0
`define BST_MASK_RST      4'h0
`define BST_LAMP_RST      8'h00
// test module numbers
`define BST_MOD_INIT      3'h1
`define BST_MOD_FMC       3'h2
`define BST_MOD_PAL_ALU   3'h3
`define BST_MOD_PAL_MEM   3'h4
`define BST_MOD_MOVER     3'h5
`define BST_MOD_LAST      3'h6
// per-module item counts
`define BST_ITEMS_FMC     3'h3
`define BST_ITEMS_MOVER   3'h7
`define BST_ITEMS_ONE     3'h1
// console message codes
`define BST_MSG_NONE      4'h0
`define BST_MSG_BUS       4'h1
`define BST_MSG_HIF       4'h2
`define BST_MSG_FMC_RW    4'h3
`define BST_MSG_FMC_MOVE  4'h4
`define BST_MSG_PAL_MEM   4'h5
`define BST_MSG_PAL_ALU   4'h6
`define BST_MSG_PAL_RW    4'h7
`define BST_MSG_NOT_FUNC  4'h8
`define BST_MSG_FUNC      4'h9
// bus responses
`define BST_RESP_OKAY     2'h0
`define BST_RESP_SLVERR   2'h2
`endif

// ---- rtl/bst_axil_slave.v ----
`timescale 1ns/10ps
`default_nettype none
`include "bst_map.vh"
module bst_axil_slave (
	input  wire        clock,
	input  wire        rst,
	input  wire [7:0]  s_awaddr,
	input  wire        s_awvalid,
	output wire        s_awready,
	input  wire [31:0] s_wdata,
	input  wire [3:0]  s_wstrb,
	input  wire        s_wvalid,
	output wire        s_wready,
	output wire [1:0]  s_bresp,
	output wire        s_bvalid,
	input  wire        s_bready,
	input  wire [7:0]  s_araddr,
	input  wire        s_arvalid,
	output wire        s_arready,
	output wire [31:0] s_rdata,
	output wire [1:0]  s_rresp,
	output wire        s_rvalid,
	input  wire        s_rready,
	input  wire [31:0] rd_data,
	output wire        wr_stb,
	output wire [7:0]  wr_addr,
	output wire [31:0] wr_data
);
	reg        awready_r;
	reg        wready_r;
	reg        bvalid_r;
	reg        arready_r;
	reg        rvalid_r;
	reg        aw_got_r;
	reg        w_got_r;
	reg        strb0_r;
	reg [7:0]  awaddr_r;
	reg [31:0] wdata_r;
	reg [31:0] rdata_r;
	reg [1:0]  bresp_r;
	reg [1:0]  rresp_r;
	wire       wr_go;

	function mapped;
		input [7:0] a;
		begin
			mapped = (a == `BST_OFS_CTRL) || (a == `BST_OFS_REPORT) ||
				(a == `BST_OFS_STATUS) || (a == `BST_OFS_LAMP) ||
				(a == `BST_OFS_IRQ_STAT) || (a == `BST_OFS_IRQ_MASK) ||
				(a == `BST_OFS_PLAN);
		end
	endfunction

	assign wr_go     = aw_got_r & w_got_r & ~bvalid_r;
	// every field sits in byte lane 0, so only that lane's strobe matters
	assign wr_stb    = wr_go & strb0_r & mapped(awaddr_r);
	assign wr_addr   = awaddr_r;
	assign wr_data   = wdata_r;
	assign s_awready = awready_r;
	assign s_wready  = wready_r;
	assign s_bvalid  = bvalid_r;
	assign s_bresp   = bresp_r;
	assign s_arready = arready_r;
	assign s_rvalid  = rvalid_r;
	assign s_rdata   = rdata_r;
	assign s_rresp   = rresp_r;

	always @(posedge clock) begin
		if (rst) begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			arready_r <= 1'b1;
			bvalid_r  <= 1'b0;
			rvalid_r  <= 1'b0;
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			strb0_r   <= 1'b0;
			awaddr_r  <= 8'h00;
			wdata_r   <= 32'h00000000;
			rdata_r   <= 32'h00000000;
			bresp_r   <= `BST_RESP_OKAY;
			rresp_r   <= `BST_RESP_OKAY;
		end else begin
			if (s_awvalid && awready_r) begin
				awaddr_r  <= s_awaddr;
				aw_got_r  <= 1'b1;
				awready_r <= 1'b0;
			end
			if (s_wvalid && wready_r) begin
				wdata_r  <= s_wdata;
				strb0_r  <= s_wstrb[0];
				w_got_r  <= 1'b1;
				wready_r <= 1'b0;
			end
			if (wr_go) begin
				bvalid_r <= 1'b1;
				bresp_r  <= mapped(awaddr_r) ? `BST_RESP_OKAY : `BST_RESP_SLVERR;
			end
			if (bvalid_r && s_bready) begin
				bvalid_r  <= 1'b0;
				aw_got_r  <= 1'b0;
				w_got_r   <= 1'b0;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end
			if (s_arvalid && arready_r) begin
				arready_r <= 1'b0;
				rvalid_r  <= 1'b1;
				rdata_r   <= mapped(s_araddr) ? rd_data : 32'h00000000;
				rresp_r   <= mapped(s_araddr) ? `BST_RESP_OKAY : `BST_RESP_SLVERR;
			end
			if (rvalid_r && s_rready) begin
				rvalid_r  <= 1'b0;
				arready_r <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ---- bench/bst_chk_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module bst_chk (
	input wire logic       clock,
	input wire logic       rst,
	input wire logic       s_bvalid,
	input wire logic       dev_bus_fault,
	input wire logic       lamp_we,
	input wire logic [7:0] lamp_wdata
);
	logic [2:0] last_mod_r;
	logic       bus_seen_r;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	always @(posedge clock) begin
		if (rst) begin
			last_mod_r <= 3'h0;
			bus_seen_r <= 1'b0;
		end else if (lamp_we) begin
			last_mod_r <= lamp_wdata[2:0];
			bus_seen_r <= lamp_wdata[3] && (lamp_wdata[2:0] != 3'h0);
		end
	end
	sequence s_last_mod;
		lamp_we && lamp_wdata[2:0] == 3'h6;
	endsequence
	sequence s_faults_only;
		lamp_we && lamp_wdata[2:0] == 3'h0 && !lamp_wdata[4];
	endsequence
	a_never_all_on: assert property (lamp_we |-> lamp_wdata != 8'hFF)
		else $error("lamp write lights every lamp");
	a_reserved_off: assert property (lamp_we |-> !lamp_wdata[4])
		else $error("reserved lamp lit");
	a_no_reset_write: assert property (disable iff (1'b0) rst && $past(rst) |-> !lamp_we)
		else $error("lamp written during reset");
	a_lamp_hold: assert property (!lamp_we && !$past(rst) |-> $stable(lamp_wdata))
		else $error("lamp value moved without a write");
	// module 1 may follow an abort or a finished run
	a_mod_order: assert property (lamp_we && lamp_wdata[2:0] != 3'h0 |->
		lamp_wdata[2:0] != 3'h7 && (lamp_wdata[2:0] == last_mod_r ||
		lamp_wdata[2:0] == last_mod_r + 3'h1 || lamp_wdata[2:0] == 3'h1))
		else $error("module number out of order");
	a_bus_sticky: assert property (lamp_we && bus_seen_r && lamp_wdata[2:0] != 3'h1
		|-> lamp_wdata[3])
		else $error("bus error lamp dropped");
	a_final_faults: assert property (s_last_mod |=> s_faults_only)
		else $error("final lamp write missing after last module");
	a_lamp_cause: assert property (lamp_we |-> s_bvalid || $past(lamp_we) ||
		$past(dev_bus_fault) || $past(dev_bus_fault, 2))
		else $error("lamp write with no cause");
endmodule
bind bst_selftest_ctrl bst_chk u_chk (.clock(clock), .rst(rst), .s_bvalid(s_bvalid),
	.dev_bus_fault(dev_bus_fault), .lamp_we(lamp_we), .lamp_wdata(lamp_wdata));
`default_nettype wire

// ---- bench/bst_lamp_dev.sv ----
`timescale 1ns/10ps
`default_nettype none
module bst_lamp_dev (
	input  wire logic       clock,
	input  wire logic       por,
	input  wire logic       lamp_we,
	input  wire logic [7:0] lamp_wdata,
	output var  logic [7:0] lamp_q
);
	// no system reset input: only power-on touches the lamps
	always @(posedge clock) begin
		if (por)
			lamp_q <= 8'hFF;
		else if (lamp_we)
			lamp_q <= lamp_wdata;
	end
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "bst_map.vh"
module tb;
	logic        clock, rst, por, dev_bus_fault, lamp_we, irq;
	logic [7:0]  s_awaddr, s_araddr, lamp_wdata, lamp_q;
	logic [31:0] s_wdata, s_rdata, rd;
	logic [3:0]  s_wstrb;
	logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic        s_arvalid, s_arready, s_rvalid, s_rready;
	logic [1:0]  s_bresp, s_rresp, rs;
	int          n_mismatch, tests_run;
	localparam logic [8:0] PW [0:2] = '{9'h001, 9'h002, 9'h004};
	localparam logic [8:0] PR [0:6] = '{9'h000, 9'h033, 9'h066, 9'h0CC, 9'h0FF, 9'h100, 9'h1FF};
	// rows: register offset, data byte, lamps expected afterwards
	localparam logic [23:0] TBL [0:27] = '{
		24'h000301, 24'h040802, 24'h040002, 24'h040002, 24'h040003, 24'h040204, 24'h040005,
		24'h040005, 24'h040005, 24'h040005, 24'h040005, 24'h040005, 24'h040005, 24'h0400A0,
		24'h000301, 24'h040002, 24'h040002, 24'h040002, 24'h040003, 24'h040004, 24'h040005,
		24'h040005, 24'h040005, 24'h040005, 24'h040005, 24'h040005, 24'h040005, 24'h040000};
	bst_selftest_ctrl dut (.clock(clock), .rst(rst), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
		.s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
		.s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
		.s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
		.dev_bus_fault(dev_bus_fault), .lamp_we(lamp_we), .lamp_wdata(lamp_wdata), .irq(irq));
	bst_lamp_dev u_dev (.clock(clock), .por(por), .lamp_we(lamp_we), .lamp_wdata(lamp_wdata),
		.lamp_q(lamp_q));
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic note(input bit ok, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (!ok) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_lamp(input logic [7:0] exp);
		note(lamp_q === exp, {24'h0, lamp_q}, {24'h0, exp});
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		note(got === exp, got, exp);
	endtask
	task automatic chk_irq(input logic exp);
		note(irq === exp, {31'h0, irq}, {31'h0, exp});
	endtask
	task automatic bound(input int i);
		if (i >= 50) begin
			n_mismatch++;
			wrap_up();
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clock);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clock);
			if (s_awvalid && s_awready)
				s_awvalid <= 1'b0;
			if (s_wvalid && s_wready)
				s_wvalid <= 1'b0;
			if (s_bvalid && s_bready)
				break;
		end
		bound(i);
		rs = s_bresp;
		s_bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a);
		int i;
		@(posedge clock);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clock);
			if (s_arvalid && s_arready)
				s_arvalid <= 1'b0;
			if (s_rvalid && s_rready)
				break;
		end
		bound(i);
		rd = s_rdata;
		rs = s_rresp;
		s_rready <= 1'b0;
	endtask
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	initial begin
		{rst, por, dev_bus_fault} = 3'h7;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
		{s_awaddr, s_araddr, s_wdata} = 48'h0;
		s_wstrb = 4'hF;
		{n_mismatch, tests_run} = 64'h0;
		repeat (2) @(posedge clock);
		por <= 1'b0;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		dev_bus_fault <= 1'b0;
		@(posedge clock);
		chk_lamp(8'hFF);
		dev_bus_fault <= 1'b1;
		@(posedge clock);
		dev_bus_fault <= 1'b0;
		axr(`BST_OFS_LAMP);
		chk_word(rd, 32'h0000_0000);
		axw(`BST_OFS_IRQ_MASK, 32'h0000_0004);
		chk_word({30'h0, rs}, {30'h0, `BST_RESP_OKAY});
		axw(`BST_OFS_CTRL, 32'h0000_0001);
		repeat (3) @(posedge clock);
		chk_lamp(8'hFF);
		chk_irq(1'b1);
		axr(`BST_OFS_STATUS);
		chk_word(rd & 32'h0000_0038, 32'h0000_0020);
		axw(`BST_OFS_IRQ_STAT, 32'h0000_0004);
		repeat (2) @(posedge clock);
		chk_irq(1'b0);
		axr(8'h40);
		chk_word({30'h0, rs}, {30'h0, `BST_RESP_SLVERR});
		chk_word(rd, 32'h0000_0000);
		for (int r = 0; r < 28; r++) begin
			if (r % 14 >= 2 && r % 14 <= 4) begin
				axr(`BST_OFS_PLAN);
				chk_word(rd & 32'h0000_01FF, {23'h0, PW[r % 14 - 2]});
			end
			if (r % 14 >= 7) begin
				axr(`BST_OFS_PLAN);
				chk_word(rd & 32'h0000_01FF, {23'h0, PR[r % 14 - 7]});
			end
			axw(TBL[r][23:16], {24'h0, TBL[r][15:8]});
			repeat (3) @(posedge clock);
			chk_lamp(TBL[r][7:0]);
			if (r % 14 == 13) begin
				axr(`BST_OFS_STATUS);
				chk_word(rd & 32'h0000_FFF8, r < 14 ? 32'h0000_8A98 : 32'h0000_9058);
			end
		end
		axw(`BST_OFS_CTRL, 32'h0000_0003);
		axw(`BST_OFS_REPORT, 32'h0000_0000);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		chk_lamp(8'h02);
		axw(`BST_OFS_CTRL, 32'h0000_0003);
		axw(`BST_OFS_REPORT, 32'h0000_0000);
		dev_bus_fault <= 1'b1;
		@(posedge clock);
		dev_bus_fault <= 1'b0;
		repeat (3) @(posedge clock);
		chk_lamp(8'h0A);
		repeat (3) axw(`BST_OFS_REPORT, 32'h0000_0000);
		repeat (3) @(posedge clock);
		chk_lamp(8'h0B);
		wrap_up();
	end
endmodule
`default_nettype wire
